// file: core/gpev_in_if.sv
// Interface carrying synchronised terminal levels and change pulses.
// Assumes both ends run on the same bus clock.
interface gpev_in_if;
  import gpev_pkg::*;

  logic [GPEV_IN_W-1:0] level;
  logic [GPEV_IN_W-1:0] change;

  modport src (output level, output change);
  modport dst (input  level, input  change);
endinterface

// file: core/gpev_input_sync.sv
// Terminal input synchroniser and change detector for the event block.
// Assumes raw terminal levels arrive asynchronously to clock.
module gpev_input_sync
  import gpev_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic [GPEV_IN_W-1:0] pins,
  gpev_in_if.src                    sync_out
);

  logic [GPEV_IN_W-1:0] meta_reg;
  logic [GPEV_IN_W-1:0] s2_reg;
  logic [GPEV_IN_W-1:0] s3_reg;
  logic [GPEV_IN_W-1:0] level_reg;
  logic [GPEV_IN_W-1:0] change_reg;
  logic [3:0]           primed_reg;

  // ----------------------------------------------------------------
  // Three-stage synchroniser
  // ----------------------------------------------------------------
  // First stage feeds only the second, nothing else looks at it
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
    end else if (ce) begin
      meta_reg <= pins;
      s2_reg   <= meta_reg;
      s3_reg   <= s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Settled level and change pulse
  // ----------------------------------------------------------------
  // A change counts only once stages two and three agree. Until the
  // stages have refilled with real pin data after reset, agreements load
  // the level silently, so a terminal held high cannot fake an edge.
  // A change inside those first few cycles is lost.
  always_ff @(posedge clock) begin
    if (rst) begin
      level_reg  <= '0;
      change_reg <= '0;
      primed_reg <= '0;
    end else if (ce) begin
      change_reg <= '0;
      for (int i = 0; i < GPEV_IN_W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level_reg[i]  <= s3_reg[i];
          change_reg[i] <= primed_reg[3] && (s3_reg[i] != level_reg[i]);
        end
      end
      primed_reg <= {primed_reg[2:0], 1'b1};
    end
  end

  assign sync_out.level  = level_reg;
  assign sync_out.change = change_reg;

endmodule

// file: core/gpev_pkg.sv
// Package for the general-purpose event block: offsets, fields, resets.
// Assumes byte offsets within the function's configuration space.
package gpev_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses in configuration space)
  // ----------------------------------------------------------------
  localparam logic [7:0] GPEV_PM_DATA_OFS   = 8'ha7;
  localparam logic [7:0] GPEV_STATUS_OFS    = 8'ha8;
  localparam logic [7:0] GPEV_ENABLE_OFS    = 8'haa;
  localparam logic [7:0] GPEV_INPUT_OFS     = 8'hac;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int         GPEV_VIDEO_BIT     = 15;
  localparam int         GPEV_POWER_BIT     = 11;
  localparam int         GPEV_HPV_BIT       = 8;
  localparam int         GPEV_IN_W          = 5;
  localparam int         GPEV_VCC_W         = 3;
  localparam int         GPEV_VPP_W         = 2;

  // Implemented status/enable bits; reserved 14:12, 10:9, 7:5 stay zero
  localparam logic [15:0] GPEV_EVENT_MASK   = 16'h891f;
  // Input register: bits 4:0 live, 15:5 zero
  localparam logic [15:0] GPEV_INPUT_MASK   = 16'h001f;

  // ----------------------------------------------------------------
  // Reset and constant values
  // ----------------------------------------------------------------
  localparam logic [7:0]  GPEV_PM_DATA_VAL  = 8'h00;
  localparam logic [15:0] GPEV_STATUS_RST   = 16'h0000;
  localparam logic [15:0] GPEV_ENABLE_RST   = 16'h0000;
  localparam logic [31:0] GPEV_RDATA_RST    = 32'h0000_0000;

  // Programming-supply request code that means 12 V
  localparam logic [1:0]  GPEV_VPP_12V      = 2'h2;

endpackage

// file: core/gpev_top.sv
// General-purpose event block: status, enable, input-level and
// power-management data registers in configuration space.
// Assumes single-cycle config read/write strobes on the bus clock and
// socket control values from logic on the same clock.
//
// Contract
// - Power-management data byte always reads zero; writes ignored.
// - Writing one clears a status bit and its event contribution.
// - Status bits set on triggers whatever the enables hold.
// - Status bit 15 sets on any change of video port enable.
// - Status bit 11 sets on any change of card or programming supply.
// - Status bit 8 sets when programming voltage moves to or from 12 V.
// - Status bits 4..0 set on level change of terminals 5,4,2,1,0.
// - Reserved status and enable bits read zero, ignore writes.
// - Event output holds until software clears the causing status bit.
// - Event output only drives when a terminal is set for events.
// - Enable bit 15 lets video port changes raise the event.
// - Enable bit 11 lets socket power changes raise the event.
// - Enable bit 8 lets 12 V request changes raise the event.
// - Enable bits 4..0 raise event only for terminals set as inputs.
// - Input bits 4..0 show current levels of terminals 5,4,2,1,0.
// - Input bits 15..5 always read zero.
module gpev_top
  import gpev_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic [7:0]            cfg_addr,
  input  wire logic [3:0]            cfg_be,
  input  wire logic [31:0]           cfg_wdata,
  input  wire logic                  cfg_wr,
  input  wire logic                  cfg_rd,
  output logic      [31:0]           cfg_rdata,
  output logic                       cfg_rvalid,
  input  wire logic [GPEV_IN_W-1:0]  multi_terminal_in,
  input  wire logic [GPEV_IN_W-1:0]  terminal_is_input,
  input  wire logic                  event_terminal_on,
  input  wire logic                  video_port_on,
  input  wire logic [GPEV_VCC_W-1:0] card_supply_req,
  input  wire logic [GPEV_VPP_W-1:0] prog_supply_req,
  output logic                       gp_event_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Dword hit for a byte offset
  function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] ofs);
    dword_hit = (addr[7:2] == ofs[7:2]);
  endfunction

  // 16-bit half of the write data at a byte offset
  function automatic logic [15:0] half_data(input logic [31:0] d, input logic [7:0] ofs);
    half_data = ofs[1] ? d[31:16] : d[15:0];
  endfunction

  // Byte enables expanded to bit mask for a 16-bit half
  function automatic logic [15:0] half_mask(input logic [3:0] be, input logic [7:0] ofs);
    logic [1:0] b;
    b = ofs[1] ? be[3:2] : be[1:0];
    half_mask = {{8{b[1]}}, {8{b[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // Terminal synchroniser
  // ----------------------------------------------------------------
  gpev_in_if term_sync ();

  gpev_input_sync u_sync (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .pins     (multi_terminal_in),
    .sync_out (term_sync.src)
  );

  // ----------------------------------------------------------------
  // Socket control change detection
  // ----------------------------------------------------------------
  logic                  video_prev_reg;
  logic [GPEV_VCC_W-1:0] vcc_prev_reg;
  logic [GPEV_VPP_W-1:0] vpp_prev_reg;
  logic                  video_chg;
  logic                  power_chg;
  logic                  hpv_chg;

  // Previous values load from the live controls at reset so that the
  // first cycle after reset raises no false event
  always_ff @(posedge clock) begin
    if (rst) begin
      video_prev_reg <= video_port_on;
      vcc_prev_reg   <= card_supply_req;
      vpp_prev_reg   <= prog_supply_req;
    end else if (ce) begin
      video_prev_reg <= video_port_on;
      vcc_prev_reg   <= card_supply_req;
      vpp_prev_reg   <= prog_supply_req;
    end
  end

  // Either direction counts
  assign video_chg = video_port_on != video_prev_reg;
  assign power_chg = (card_supply_req != vcc_prev_reg) ||
                     (prog_supply_req != vpp_prev_reg);
  assign hpv_chg   = (prog_supply_req == GPEV_VPP_12V) !=
                     (vpp_prev_reg == GPEV_VPP_12V);

  // ----------------------------------------------------------------
  // Event status and enable registers
  // ----------------------------------------------------------------
  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic [15:0] enable_reg;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic        st_wr;
  logic        en_wr;

  assign st_wr = cfg_wr && dword_hit(cfg_addr, GPEV_STATUS_OFS);
  assign en_wr = cfg_wr && dword_hit(cfg_addr, GPEV_ENABLE_OFS);

  // Trigger vector, independent of the enables
  always_comb begin
    set_vec                          = '0;
    set_vec[GPEV_VIDEO_BIT]          = video_chg;
    set_vec[GPEV_POWER_BIT]          = power_chg;
    set_vec[GPEV_HPV_BIT]            = hpv_chg;
    set_vec[GPEV_IN_W-1:0]           = term_sync.change;
  end

  // Write-one-to-clear, limited by byte enables and implemented bits
  assign clr_vec = st_wr ? (half_data(cfg_wdata, GPEV_STATUS_OFS) &
                            half_mask(cfg_be, GPEV_STATUS_OFS) &
                            GPEV_EVENT_MASK) : 16'h0000;

  // Set applied after clear so a simultaneous event survives
  assign status_next = ((status_reg & ~clr_vec) | set_vec) & GPEV_EVENT_MASK;

  // Status flags
  always_ff @(posedge clock) begin
    if (rst) begin
      status_reg <= GPEV_STATUS_RST;
    end else if (ce) begin
      status_reg <= status_next;
    end
  end

  // Enable bits; reserved positions never take a one
  always_ff @(posedge clock) begin
    if (rst) begin
      enable_reg <= GPEV_ENABLE_RST;
    end else if (ce && en_wr) begin
      enable_reg <= (enable_reg & ~half_mask(cfg_be, GPEV_ENABLE_OFS)) |
                    (half_data(cfg_wdata, GPEV_ENABLE_OFS) &
                     half_mask(cfg_be, GPEV_ENABLE_OFS) & GPEV_EVENT_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Event output
  // ----------------------------------------------------------------
  logic [15:0] gate_vec;
  logic        event_any;

  // Terminal events only count for terminals configured as inputs
  always_comb begin
    gate_vec                = 16'hffff;
    gate_vec[GPEV_IN_W-1:0] = terminal_is_input;
  end

  // Level from pending status: stays up until the flag is cleared
  assign event_any = |(status_next & enable_reg & gate_vec);

  // Registered so the pin comes straight from a flop
  always_ff @(posedge clock) begin
    if (rst) begin
      gp_event_out <= 1'b0;
    end else if (ce) begin
      gp_event_out <= event_terminal_on && event_any;
    end
  end
  // Enables act only on the output, never on the flags, so software
  // can still poll video, power and 12 V request changes while the
  // event output is masked

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rd_word;

  // Unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (dword_hit(cfg_addr, GPEV_PM_DATA_OFS)) begin
      rd_word[31:24] = GPEV_PM_DATA_VAL;
    end else if (dword_hit(cfg_addr, GPEV_STATUS_OFS)) begin
      rd_word = {enable_reg & GPEV_EVENT_MASK, status_reg & GPEV_EVENT_MASK};
    end else if (dword_hit(cfg_addr, GPEV_INPUT_OFS)) begin
      rd_word[15:0] = {11'h000, term_sync.level} & GPEV_INPUT_MASK;
    end
  end

  // Data one cycle after the strobe, held until the next read
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_rdata  <= GPEV_RDATA_RST;
      cfg_rvalid <= 1'b0;
    end else if (ce) begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= rd_word;
      end
    end
  end

endmodule

// file: test/gpev_chk.sv
// Checker for the general-purpose event block, watching top ports only.
// Assumes one-cycle config strobes on the bus clock.
module gpev_chk
  import gpev_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire logic [7:0]            cfg_addr,
  input wire logic [3:0]            cfg_be,
  input wire logic [31:0]           cfg_wdata,
  input wire logic                  cfg_wr,
  input wire logic                  cfg_rd,
  input wire logic [31:0]           cfg_rdata,
  input wire logic                  cfg_rvalid,
  input wire logic [GPEV_IN_W-1:0]  terminal_is_input,
  input wire logic                  event_terminal_on,
  input wire logic                  video_port_on,
  input wire logic [GPEV_VCC_W-1:0] card_supply_req,
  input wire logic [GPEV_VPP_W-1:0] prog_supply_req,
  input wire logic                  gp_event_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // --
  // Enable shadow and sequences
  // --
  logic [15:0] en_reg;

  // Shadow of the enable half, so socket checks know what is armed
  always_ff @(posedge clock) begin
    if (rst) begin
      en_reg <= '0;
    end else if (ce && cfg_wr && cfg_addr[7:2] == 6'h2a) begin
      if (cfg_be[2]) en_reg[7:0] <= cfg_wdata[23:16] & GPEV_EVENT_MASK[7:0];
      if (cfg_be[3]) en_reg[15:8] <= cfg_wdata[31:24] & GPEV_EVENT_MASK[15:8];
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence rd_at(logic [5:0] dw);
    ce && cfg_rd && cfg_addr[7:2] == dw;
  endsequence
  // Change checks are only fair when no write or freeze intervenes
  sequence calm;
    ce && $past(ce) && !cfg_wr;
  endsequence

  rvalid_follow_a: assert property (ce |=> cfg_rvalid == $past(cfg_rd)) else $error("read valid wrong");
  pm_zero_a: assert property (rd_at(6'h29) |=> cfg_rdata == '0)
    else $error("power data not zero");
  status_rsvd_a: assert property (rd_at(6'h2a) |=> (cfg_rdata & ~{2{GPEV_EVENT_MASK}}) == '0)
    else $error("reserved bit set");
  input_high_a: assert property (rd_at(6'h2b) |=> cfg_rdata[31:5] == '0)
    else $error("input upper bits set");
  gate_off_a: assert property (ce && !event_terminal_on |=> !gp_event_out)
    else $error("event without terminal");
  // An enable write lands one cycle before it reaches the output pin
  event_hold_a: assert property (
    calm ##0 (!$past(cfg_wr) && gp_event_out && $stable(terminal_is_input) && $stable(event_terminal_on))
    |=> gp_event_out) else $error("event dropped early");
  clear_all_a: assert property (
    ce && $past(ce) && cfg_wr && cfg_addr[7:2] == 6'h2a && cfg_be[1:0] == 2'h3 && cfg_wdata[15:0] == 16'hffff
    && terminal_is_input == '0 && $stable(video_port_on) && $stable(card_supply_req) && $stable(prog_supply_req)
    |=> !gp_event_out) else $error("event kept after clear");
  video_evt_a: assert property (
    calm ##0 ($changed(video_port_on) && en_reg[15] && event_terminal_on) |=> gp_event_out)
    else $error("video change missed");
  power_evt_a: assert property (
    calm ##0 (($changed(card_supply_req) || $changed(prog_supply_req)) && en_reg[11] && event_terminal_on)
    |=> gp_event_out) else $error("power change missed");
  hpv_evt_a: assert property (
    calm ##0 ($changed(prog_supply_req == GPEV_VPP_12V) && en_reg[8] && event_terminal_on) |=> gp_event_out)
    else $error("12 V change missed");
endmodule

bind gpev_top gpev_chk u_chk (
  .clock(clock), .rst(rst), .ce(ce), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .terminal_is_input(terminal_is_input), .event_terminal_on(event_terminal_on),
  .video_port_on(video_port_on), .card_supply_req(card_supply_req),
  .prog_supply_req(prog_supply_req), .gp_event_out(gp_event_out)
);

// file: test/gpev_partner.sv
// Partner model: general-purpose terminals and the system event sink.
// Assumes toggle requests arrive on the bus clock.
module gpev_partner
  import gpev_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic [GPEV_IN_W-1:0] tgl,
  input  wire logic                 gp_event_out,
  output logic      [GPEV_IN_W-1:0] pins,
  output int                        rises
);
  timeunit 1ns;
  timeprecision 1ps;
  // Levels move 13 ns after a request, away from the sampling edge
  initial pins = '0;
  always @(posedge clock) if (|tgl) pins <= #13 pins ^ tgl;
  // Count events seen by the system side
  initial rises = 0;
  always @(posedge gp_event_out) rises++;
endmodule

// file: test/tb.sv
// Self-checking bench for the general-purpose event block.
// Assumes gpev_partner on the terminals and gpev_chk bound to the top.
module tb
  import gpev_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clock = 0, rst = 1, ce = 1, ets = 1, cfg_wr = 0, cfg_rd = 0, vid = 0, gp_event_out, cfg_rvalid;
  logic [7:0]            cfg_addr = '0;
  logic [3:0]            cfg_be = '0;
  logic [31:0]           cfg_wdata = '0, cfg_rdata, d;
  logic [15:0]           en, ex;
  logic [GPEV_IN_W-1:0]  pins, tgl = '0, is_in = '0, lv = '0;
  logic [GPEV_VCC_W-1:0] card = '0, nc;
  logic [GPEV_VPP_W-1:0] prog = '0, np;
  int                    bad_count = 0, num_checks = 0, rises, n;

  always #25 clock = ~clock;
  gpev_top DUT (.clock(clock), .rst(rst), .ce(ce), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .multi_terminal_in(pins),
    .terminal_is_input(is_in), .event_terminal_on(ets), .video_port_on(vid), .card_supply_req(card),
    .prog_supply_req(prog), .gp_event_out(gp_event_out));
  gpev_partner far_side (.clock(clock), .tgl(tgl), .gp_event_out(gp_event_out), .pins(pins), .rises(rises));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Write; tv flips the video bit in the same cycle
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] w, input logic tv);
    @(posedge clock);
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= w;
    cfg_wr <= 1'b1;
    if (tv) vid <= ~vid;
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge clock);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clock);
    cfg_rd <= 1'b0;
    #1;
    for (k = 0; k < 4 && cfg_rvalid !== 1'b1; k++) @(posedge clock) #1;
    // A timed-out read counts and the run goes on to the verdict
    if (k == 4) bad_count++;
    d = cfg_rdata;
  endtask
  // Socket status bits expected from an old and a new setting
  function automatic logic [15:0] sock_exp(input logic [2:0] c0, c1, input logic [1:0] p0, p1);
    sock_exp = '0;
    sock_exp[GPEV_POWER_BIT] = (c0 != c1) || (p0 != p1);
    sock_exp[GPEV_HPV_BIT] = (p0 == GPEV_VPP_12V) != (p1 == GPEV_VPP_12V);
  endfunction

  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end

  initial begin
    void'($urandom(73));
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    wr(GPEV_PM_DATA_OFS, 4'hf, '1, 0);
    rd(GPEV_PM_DATA_OFS);
    chk(d, '0);
    rd(8'hb0);
    chk(d, '0);
    wr(GPEV_STATUS_OFS, 4'hf, '1, 0);
    rd(GPEV_STATUS_OFS);
    chk(d, {GPEV_EVENT_MASK, 16'h0});
    // Socket triggers under random enables, both ways through 12 V
    for (int i = 0; i < 12; i++) begin
      en = 16'($urandom()) & GPEV_EVENT_MASK;
      nc = (i % 3 == 1) ? GPEV_VCC_W'($urandom()) : card;
      np = (i % 3 != 2) ? prog : (prog == GPEV_VPP_12V) ? GPEV_VPP_W'($urandom() % 2) : GPEV_VPP_12V;
      ex = sock_exp(card, nc, prog, np);
      ex[GPEV_VIDEO_BIT] = (i % 3 == 0);
      wr(GPEV_STATUS_OFS, 4'hf, {en, 16'hffff}, 0);
      card <= nc;
      prog <= np;
      if (i % 3 == 0) vid <= ~vid;
      repeat (2) @(posedge clock);
      #1 chk(32'(gp_event_out), 32'(|(ex & en)));
      rd(GPEV_STATUS_OFS);
      chk(d, {en, ex});
      chk(32'(gp_event_out), 32'(|(ex & en)));
    end
    wr(GPEV_STATUS_OFS, 4'h3, 32'hffff, 0);
    wr(GPEV_STATUS_OFS, 4'h3, 32'h8000, 1);
    rd(GPEV_STATUS_OFS);
    chk(32'(d[GPEV_VIDEO_BIT]), 32'h1);
    wr(GPEV_STATUS_OFS, 4'hf, '1, 0);
    ets <= 1'b0;
    vid <= ~vid;
    repeat (2) @(posedge clock);
    #1 chk(32'(gp_event_out), 32'h0);
    @(posedge clock) ets <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk(32'(gp_event_out), 32'h1);
    // Freeze: a video change while ce is low must wait for ce
    wr(GPEV_STATUS_OFS, 4'h3, 32'hffff, 0);
    ce <= 1'b0;
    vid <= ~vid;
    repeat (3) @(posedge clock);
    #1 chk(32'(gp_event_out), 32'h0);
    @(posedge clock) ce <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk(32'(gp_event_out), 32'h1);
    // Terminal changes, each under a random input-gate setting
    for (int j = 0; j < GPEV_IN_W; j++) begin
      wr(GPEV_STATUS_OFS, 4'hf, 32'h001f_ffff, 0);
      is_in <= GPEV_IN_W'($urandom());
      tgl <= GPEV_IN_W'(1 << j);
      lv[j] = ~lv[j];
      @(posedge clock) tgl <= '0;
      for (n = 0; n < 8; n++) begin
        rd(GPEV_STATUS_OFS);
        if (d[j] === 1'b1) break;
      end
      chk(d, {16'h001f, 16'(1 << j)});
      chk(32'(gp_event_out), 32'(is_in[j]));
      rd(GPEV_INPUT_OFS);
      chk(d, 32'(lv));
    end
    // Mid-run reset with terminals away from zero: no false change
    @(posedge clock) rst <= 1'b1;
    @(posedge clock) rst <= 1'b0;
    repeat (8) @(posedge clock);
    rd(GPEV_STATUS_OFS);
    chk(d, 32'h0);
    chk(32'(gp_event_out), 32'h0);
    rd(GPEV_INPUT_OFS);
    chk(d, 32'(lv));
    chk(32'(rises > 0), 32'h1);
    wrap_up();
  end
endmodule
